/* common/mcrs_pkg.sv */
// Package for memory clock ratio select constants and types
package mcrs_pkg;
	localparam int SEL_LSB = 10;
	localparam int SEL_MSB = 11;
	localparam logic [1:0] SEL_RESET = 2'h0;
	localparam logic [1:0] BUS_00 = 2'h0;
	localparam logic [1:0] BUS_01 = 2'h1;
	localparam logic [1:0] BUS_10 = 2'h2;
	localparam logic [1:0] SEL_00 = 2'h0;
	localparam logic [1:0] SEL_01 = 2'h1;
	localparam logic [1:0] SEL_10 = 2'h2;
	// Memory rates in MHz; the 333 grade actually runs at 320 on the fastest bus
	localparam logic [9:0] RATE_NONE = 10'h000;
	localparam logic [9:0] RATE_266 = 10'h10A;
	localparam logic [9:0] RATE_333 = 10'h14D;
	localparam logic [9:0] RATE_320 = 10'h140;
	localparam logic [9:0] RATE_400 = 10'h190;
	typedef enum logic [2:0] {
		MCRS_RATE_RSVD,
		MCRS_RATE_266,
		MCRS_RATE_333,
		MCRS_RATE_320,
		MCRS_RATE_400
	} mcrs_rate_t;
endpackage

/* logic/mcrs_ratio_select.sv */
// Memory clock ratio selection with synchronization-gated apply
// Functional notes
// - Two-bit read/write speed select, bits 11:10, reset 00
// - Bus 00/sel 01, bus 01/sel 00: 266 MHz
// - Bus 01 with select 01: 333 MHz
// - Bus 10 with select 01: 320 MHz
// - Bus 10 with select 10: 400 MHz; else reserved
// - Memory I/O clock is double memory clock
// - New select applies only after sync sequence
`timescale 1ns/1ps
`default_nettype none
module mcrs_ratio_select (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic cfg_wr_i,
	input wire logic [15:0] cfg_wdata_i,
	input wire logic [1:0] host_bus_speed_indication_i,
	input wire logic sync_done_i,
	output logic [1:0] memory_speed_select_o,
	output logic [1:0] applied_select_o,
	output logic [9:0] mem_clk_mhz_o,
	output logic [10:0] mem_io_clk_mhz_o,
	output logic [2:0] rate_code_o,
	output logic rate_reserved_o,
	output logic apply_pending_o
);
	logic [1:0] bus_meta_reg;
	logic [1:0] bus_sync_reg;
	logic [1:0] bus_prev_reg;
	logic [1:0] bus_word_reg;
	logic done_meta_reg;
	logic done_sync_reg;
	logic [1:0] sel_reg;
	logic [1:0] applied_reg;
	logic pending_reg;
	logic [9:0] rate_next;
	mcrs_pkg::mcrs_rate_t code_next;

	// Strap-like bus indication and sync completion come from outside
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			bus_meta_reg <= 2'h0;
			bus_sync_reg <= 2'h0;
			done_meta_reg <= 1'b0;
			done_sync_reg <= 1'b0;
		end else begin
			bus_meta_reg <= host_bus_speed_indication_i;
			bus_sync_reg <= bus_meta_reg;
			done_meta_reg <= sync_done_i;
			done_sync_reg <= done_meta_reg;
		end
	end

	// Word taken only when two samples agree, so bit skew cannot flash a stray ratio
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			bus_prev_reg <= mcrs_pkg::BUS_00;
			bus_word_reg <= mcrs_pkg::BUS_00;
		end else begin
			bus_prev_reg <= bus_sync_reg;
			if (bus_sync_reg == bus_prev_reg) begin
				bus_word_reg <= bus_sync_reg;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			sel_reg <= mcrs_pkg::SEL_RESET;
		end else if (cfg_wr_i) begin
			sel_reg <= cfg_wdata_i[mcrs_pkg::SEL_MSB:mcrs_pkg::SEL_LSB];
		end
	end

	// Write wins over a completion in the same cycle: it needs its own sync
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			applied_reg <= mcrs_pkg::SEL_RESET;
			pending_reg <= 1'b0;
		end else if (cfg_wr_i) begin
			pending_reg <= 1'b1;
		end else if (pending_reg && done_sync_reg) begin
			applied_reg <= sel_reg;
			pending_reg <= 1'b0;
		end
	end

	function automatic mcrs_pkg::mcrs_rate_t rate_of(input logic [1:0] bus, input logic [1:0] sel);
		mcrs_pkg::mcrs_rate_t r;
		r = mcrs_pkg::MCRS_RATE_RSVD;
		if ((bus == mcrs_pkg::BUS_00 && sel == mcrs_pkg::SEL_01) ||
			(bus == mcrs_pkg::BUS_01 && sel == mcrs_pkg::SEL_00)) begin
			r = mcrs_pkg::MCRS_RATE_266;
		end else if (bus == mcrs_pkg::BUS_01 && sel == mcrs_pkg::SEL_01) begin
			r = mcrs_pkg::MCRS_RATE_333;
		end else if (bus == mcrs_pkg::BUS_10 && sel == mcrs_pkg::SEL_01) begin
			r = mcrs_pkg::MCRS_RATE_320;
		end else if (bus == mcrs_pkg::BUS_10 && sel == mcrs_pkg::SEL_10) begin
			r = mcrs_pkg::MCRS_RATE_400;
		end
		return r;
	endfunction

	always_comb begin
		code_next = rate_of(bus_word_reg, applied_reg);
		case (code_next)
			mcrs_pkg::MCRS_RATE_266: rate_next = mcrs_pkg::RATE_266;
			mcrs_pkg::MCRS_RATE_333: rate_next = mcrs_pkg::RATE_333;
			mcrs_pkg::MCRS_RATE_320: rate_next = mcrs_pkg::RATE_320;
			mcrs_pkg::MCRS_RATE_400: rate_next = mcrs_pkg::RATE_400;
			default: rate_next = mcrs_pkg::RATE_NONE;
		endcase
	end

	// Reserved pairs report zero rate; behaviour there is not to be relied on
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			mem_clk_mhz_o <= mcrs_pkg::RATE_NONE;
			mem_io_clk_mhz_o <= 11'h000;
			rate_code_o <= 3'h0;
			rate_reserved_o <= 1'b1;
			memory_speed_select_o <= mcrs_pkg::SEL_RESET;
			applied_select_o <= mcrs_pkg::SEL_RESET;
			apply_pending_o <= 1'b0;
		end else begin
			mem_clk_mhz_o <= rate_next;
			mem_io_clk_mhz_o <= {rate_next, 1'b0};
			rate_code_o <= code_next;
			rate_reserved_o <= (code_next == mcrs_pkg::MCRS_RATE_RSVD);
			memory_speed_select_o <= sel_reg;
			applied_select_o <= applied_reg;
			apply_pending_o <= pending_reg;
		end
	end

	property p_io_double;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		mem_io_clk_mhz_o == {mem_clk_mhz_o, 1'b0};
	endproperty
	a_io_double: assert property (p_io_double) else $error("io clock not double");

	property p_hold_until_sync;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(pending_reg && !done_sync_reg) |=> $stable(applied_reg);
	endproperty
	a_hold_until_sync: assert property (p_hold_until_sync) else $error("applied early");

	sequence s_write;
		cfg_wr_i;
	endsequence
	sequence s_sync_seen;
		!cfg_wr_i && pending_reg && done_sync_reg;
	endsequence
	property p_apply;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_sync_seen |=> (applied_reg == $past(sel_reg)) && !pending_reg;
	endproperty
	a_apply: assert property (p_apply) else $error("sync did not apply");

	property p_write_pending;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_write |=> pending_reg ##1 apply_pending_o;
	endproperty
	a_write_pending: assert property (p_write_pending) else $error("write not pending");

	property p_sel_store;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		cfg_wr_i |=> sel_reg == $past(cfg_wdata_i[11:10]);
	endproperty
	a_sel_store: assert property (p_sel_store) else $error("select not stored");

	property p_266;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		((bus_word_reg == 2'h0 && applied_reg == 2'h1) ||
		(bus_word_reg == 2'h1 && applied_reg == 2'h0)) |=> mem_clk_mhz_o == 10'h10A;
	endproperty
	a_266: assert property (p_266) else $error("266 wrong");

	property p_333;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(bus_word_reg == 2'h1 && applied_reg == 2'h1) |=> mem_clk_mhz_o == 10'h14D;
	endproperty
	a_333: assert property (p_333) else $error("333 wrong");

	property p_320;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(bus_word_reg == 2'h2 && applied_reg == 2'h1) |=> mem_clk_mhz_o == 10'h140;
	endproperty
	a_320: assert property (p_320) else $error("320 wrong");

	property p_400;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(bus_word_reg == 2'h2 && applied_reg == 2'h2) |=> mem_clk_mhz_o == 10'h190;
	endproperty
	a_400: assert property (p_400) else $error("400 wrong");

	property p_reserved;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		rate_reserved_o |-> mem_clk_mhz_o == 10'h000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved rate nonzero");

	sequence s_write_on_sync;
		cfg_wr_i && pending_reg && done_sync_reg;
	endsequence
	property p_write_wins;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_write_on_sync |=> pending_reg && $stable(applied_reg);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("write lost to sync");

	property p_idle_ignore;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		!pending_reg |=> $stable(applied_reg);
	endproperty
	a_idle_ignore: assert property (p_idle_ignore) else $error("idle sync applied");

	// Skewed bits of the indication must not reach the rate decode
	property p_bus_settle;
		@(posedge sys_clk_i) disable iff (!rst_b_i)
		(bus_sync_reg != bus_prev_reg) |=> $stable(bus_word_reg);
	endproperty
	a_bus_settle: assert property (p_bus_settle) else $error("bus word unsettled");
endmodule
`default_nettype wire

/* verif/mcrs_testbench.sv */
// Self-checking testbench for memory clock ratio selection
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cfg_wr_i = 1'b0;
	logic [15:0] cfg_wdata_i = 16'h0000;
	logic [1:0] bus = 2'h0;
	logic sync_done_i = 1'b0;
	logic [1:0] sel_o;
	logic [1:0] app_o;
	logic [9:0] clk_o;
	logic [10:0] io_o;
	logic [2:0] code_o;
	logic rsvd_o;
	logic pend_o;
	int fails = 0;
	int checked = 0;
	mcrs_ratio_select u_mcrs_ratio_select (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i), .host_bus_speed_indication_i(bus),
		.sync_done_i(sync_done_i), .memory_speed_select_o(sel_o), .applied_select_o(app_o),
		.mem_clk_mhz_o(clk_o), .mem_io_clk_mhz_o(io_o), .rate_code_o(code_o),
		.rate_reserved_o(rsvd_o), .apply_pending_o(pend_o));
	initial forever #12.5 sys_clk_i = ~sys_clk_i;
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask
	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: %s got %0d expected %0d", $time, what, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("Counts: fails %0d checked %0d", fails, checked);
		if (fails == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	function automatic logic [12:0] expect_rate(input logic [1:0] b, input logic [1:0] s);
		case ({b, s})
			4'h1, 4'h4: expect_rate = {3'h1, mcrs_pkg::RATE_266};
			4'h5: expect_rate = {3'h2, mcrs_pkg::RATE_333};
			4'h9: expect_rate = {3'h3, mcrs_pkg::RATE_320};
			4'hA: expect_rate = {3'h4, mcrs_pkg::RATE_400};
			default: expect_rate = {3'h0, mcrs_pkg::RATE_NONE};
		endcase
	endfunction
	task automatic sync_pulse;
		int i;
		sync_done_i = 1'b1;
		step(1);
		sync_done_i = 1'b0;
		for (i = 0; i < 10 && pend_o !== 1'b0; i++) step(1);
		if (pend_o !== 1'b0) begin
			fails++;
			complete_run();
		end
		step(2);
	endtask
	task automatic check_reset;
		step(8);
		chk(sel_o, mcrs_pkg::SEL_RESET, "reset select");
		chk(rsvd_o, 1'b1, "reset reserved");
		rst_b_i = 1'b1;
		step(3);
		chk(sel_o, mcrs_pkg::SEL_RESET, "select after reset");
	endtask
	task automatic check_combo(input logic [1:0] b, input logic [1:0] s);
		logic [12:0] e;
		logic [1:0] old;
		e = expect_rate(b, s);
		old = app_o;
		bus = b;
		cfg_wdata_i = {4'hF, s, 10'h3FF};
		cfg_wr_i = 1'b1;
		step(1);
		cfg_wr_i = 1'b0;
		step(4);
		chk(sel_o, s, "select");
		chk(pend_o, 1'b1, "pending");
		chk(app_o, old, "held");
		sync_pulse();
		chk(app_o, s, "applied");
		chk(clk_o, e[9:0], "rate");
		chk(io_o, {e[9:0], 1'b0}, "io clock");
		chk(code_o, e[12:10], "code");
		chk(rsvd_o, e[12:10] == 3'h0, "reserved");
	endtask
	task automatic check_back_to_back;
		bus = mcrs_pkg::BUS_10;
		cfg_wdata_i = 16'h0800;
		cfg_wr_i = 1'b1;
		step(1);
		cfg_wdata_i = 16'h0400;
		step(1);
		cfg_wr_i = 1'b0;
		step(3);
		chk(sel_o, mcrs_pkg::SEL_01, "last write wins");
		sync_pulse();
		chk(clk_o, mcrs_pkg::RATE_320, "rate after pair");
	endtask
	task automatic check_idle_sync;
		sync_pulse();
		chk(app_o, mcrs_pkg::SEL_01, "idle sync");
		chk(pend_o, 1'b0, "idle pending");
	endtask
	task automatic check_write_wins;
		cfg_wdata_i = 16'h0800;
		cfg_wr_i = 1'b1;
		step(1);
		cfg_wr_i = 1'b0;
		sync_done_i = 1'b1;
		step(1);
		sync_done_i = 1'b0;
		step(1);
		cfg_wdata_i = 16'h0400;
		cfg_wr_i = 1'b1;
		step(1);
		cfg_wr_i = 1'b0;
		step(3);
		chk(pend_o, 1'b1, "write beats sync");
		chk(app_o, mcrs_pkg::SEL_01, "first value skipped");
		chk(sel_o, mcrs_pkg::SEL_01, "second value stored");
		sync_pulse();
		chk(app_o, mcrs_pkg::SEL_01, "second value applied");
		chk(pend_o, 1'b0, "cleared after sync");
		chk(clk_o, mcrs_pkg::RATE_320, "rate after late write");
	endtask
	task automatic check_mid_reset;
		rst_b_i = 1'b0;
		step(3);
		chk(sel_o, mcrs_pkg::SEL_RESET, "mid reset select");
		chk(app_o, mcrs_pkg::SEL_RESET, "mid reset applied");
		chk(clk_o, mcrs_pkg::RATE_NONE, "mid reset rate");
		rst_b_i = 1'b1;
		step(1);
		chk(rsvd_o, 1'b1, "first edge after release");
		cfg_wdata_i = 16'h0400;
		cfg_wr_i = 1'b1;
		step(1);
		cfg_wr_i = 1'b0;
		step(2);
		chk(pend_o, 1'b1, "pending after release");
		sync_pulse();
		chk(clk_o, mcrs_pkg::RATE_320, "rate after release");
	endtask
	initial begin
		check_reset();
		check_combo(2'h0, 2'h1);
		check_combo(2'h1, 2'h0);
		check_combo(2'h1, 2'h1);
		check_combo(2'h2, 2'h1);
		check_combo(2'h2, 2'h2);
		check_combo(2'h0, 2'h0);
		check_combo(2'h3, 2'h3);
		check_back_to_back();
		check_idle_sync();
		check_write_wins();
		check_mid_reset();
		complete_run();
	end
endmodule
`default_nettype wire
